// ==== src/tpr_regs.sv ====
// Eight-link overflow flag, pattern test and transmit payload indirect access registers
// How it works
// RULE1: CRC flag drives interrupt only while its enable bit is set.
// RULE2: Line-violation flag drives interrupt only while its enable bit is set.
// RULE3: Pattern error counter overflow sets flag bit 7 of flags 0.
// RULE4: Digital service counter overflow sets flag bit 4 of flags 0.
// RULE5: Alignment change counter overflow sets flag bit 3 of flags 0.
// RULE6: Frame loss counter overflow sets flag bit 2 of flags 0.
// RULE7: Framing bit counter overflow sets flag bit 1 of flags 0.
// RULE8: CRC counter overflow sets flag bit 0 of flags 0.
// RULE9: Line violation overflow sets bit 0 of flags 1; others reserved.
// RULE10: Flags clear only on writing one; writing zero keeps them.
// RULE11: Mode 00 is unframed, all 24 channels, per-channel selection ignored.
// RULE12: Mode 01 works on full bytes of selected channels only.
// RULE13: Mode 10 uses seven upper bits of selected channels; 11 reserved.
// RULE14: Direction 0 generates on transmit; 1 generates on receive.
// RULE15: Only a rising edge of the start bit starts the pattern engine.
// RULE16: Busy reads one during an indirect access, else zero; resets zero.
// RULE17: Software waits for busy low before a new indirect access.
// RULE18: Access direction bit 7: zero writes, one reads.
// RULE19: Indirect address valid only in 01-18, 21-38, 41-58 hex.
// RULE20: Every register exists once per link, link picked by leading digit.
// RULE21: Software loads data before writing control for an indirect write.
// RULE22: Indirect read places the addressed byte into the data register.
// RULE23: Interrupt is high while any enabled flag is set.
//
// Decided for this implementation: the plain strobed port.
module tpr_regs
   import tpr_pkg::*;
#(
   parameter int NUM_LINKS = 8
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Register port: address bits 10:8 pick the link, 7:0 the offset
   input wire logic [10:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Counter overflow events, one pulse bit per link
   input wire logic [NUM_LINKS-1:0] i_pattern_err_ovf,
   input wire logic [NUM_LINKS-1:0] i_digital_service_ovf,
   input wire logic [NUM_LINKS-1:0] i_align_change_ovf,
   input wire logic [NUM_LINKS-1:0] i_frame_loss_ovf,
   input wire logic [NUM_LINKS-1:0] i_framing_bit_ovf,
   input wire logic [NUM_LINKS-1:0] i_crc_error_ovf,
   input wire logic [NUM_LINKS-1:0] i_line_violation_ovf,
   // Interrupt
   output logic o_irq,
   // Pattern generator and detector control
   output logic [2*NUM_LINKS-1:0] o_pattern_extract_mode,
   output logic [NUM_LINKS-1:0] o_pattern_unframed,
   output logic [NUM_LINKS-1:0] o_pattern_msb7_only,
   output logic [NUM_LINKS-1:0] o_pattern_gen_in_rx,
   output logic [NUM_LINKS-1:0] o_pattern_start,
   // Indirect access state
   output logic [NUM_LINKS-1:0] o_access_busy
);
   import tpr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta_reg;
   logic rst_sync_reg;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic reg_hit(input logic [10:0] addr, input int link,
                                    input logic [7:0] off);
      reg_hit = (addr[10:8] == 3'(link)) && (addr[7:0] == off); // [RULE20]
   endfunction

   function automatic logic ind_addr_ok(input logic [6:0] a);
      ind_addr_ok = ((a >= IND_LO0) && (a <= IND_HI0)) ||
                    ((a >= IND_LO1) && (a <= IND_HI1)) ||
                    ((a >= IND_LO2) && (a <= IND_HI2)); // [RULE19]
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per-link register slice

   logic [7:0] link_rdata [NUM_LINKS];
   logic [NUM_LINKS-1:0] link_irq;

   for (genvar l = 0; l < NUM_LINKS; l++)
   begin : g_link
      logic crc_error_overflow_irq_enable_reg;
      logic crc_error_overflow_irq_enable_next;
      logic line_violation_overflow_irq_enable_reg;
      logic line_violation_overflow_irq_enable_next;
      logic [7:0] flags0_reg;
      logic [7:0] flags0_next;
      logic line_violation_overflow_flag_reg;
      logic line_violation_overflow_flag_next;
      logic [1:0] mode_reg;
      logic [1:0] mode_next;
      logic dir_reg;
      logic dir_next;
      logic start_bit_reg;
      logic start_bit_next;
      logic start_pulse_reg;
      logic start_pulse_next;
      logic unframed_reg;
      logic unframed_next;
      logic msb7_reg;
      logic msb7_next;
      logic [7:0] ctrl_reg;
      logic [7:0] ctrl_next;
      logic [7:0] data_reg;
      logic [7:0] data_next;
      tpr_acc_e state_reg;
      tpr_acc_e state_next;
      logic [3:0] cnt_reg;
      logic [3:0] cnt_next;
      logic busy_reg;
      logic busy_next;
      logic mem_we;
      logic [7:0] ind_mem [128];
      logic [7:0] set0;
      logic [7:0] clr0;
      logic wr_ctrl;
      logic wr_cfg;

      // Overflow flags and interrupt enables
      always_comb
      begin
         set0 = RST_BYTE;
         set0[BIT_PAT_FLAG] = i_pattern_err_ovf[l]; // [RULE3]
         set0[BIT_DDS_FLAG] = i_digital_service_ovf[l]; // [RULE4]
         set0[BIT_COFA_FLAG] = i_align_change_ovf[l]; // [RULE5]
         set0[BIT_OOF_FLAG] = i_frame_loss_ovf[l]; // [RULE6]
         set0[BIT_FER_FLAG] = i_framing_bit_ovf[l]; // [RULE7]
         set0[BIT_CRC_FLAG] = i_crc_error_ovf[l]; // [RULE8]
         clr0 = (i_wr && reg_hit(i_addr, l, OFF_FLAGS0)) ? i_wdata : RST_BYTE;
         // Only implemented bits can ever hold a one
         flags0_next = ((flags0_reg & ~clr0) | set0); // [RULE10]
         line_violation_overflow_flag_next = i_line_violation_ovf[l] ||
            (line_violation_overflow_flag_reg &&
             !(i_wr && reg_hit(i_addr, l, OFF_FLAGS1) && i_wdata[BIT_LCV_FLAG])); // [RULE9] [RULE10]

         crc_error_overflow_irq_enable_next = crc_error_overflow_irq_enable_reg;
         if (i_wr && reg_hit(i_addr, l, OFF_IRQ_EN0))
            crc_error_overflow_irq_enable_next = i_wdata[BIT_CRC_EN];
         line_violation_overflow_irq_enable_next = line_violation_overflow_irq_enable_reg;
         if (i_wr && reg_hit(i_addr, l, OFF_IRQ_EN1))
            line_violation_overflow_irq_enable_next = i_wdata[BIT_LCV_EN];
      end

      // Pattern test configuration
      always_comb
      begin
         wr_cfg = i_wr && reg_hit(i_addr, l, OFF_PAT_CFG);
         mode_next = mode_reg;
         dir_next = dir_reg;
         start_bit_next = start_bit_reg;
         if (wr_cfg)
         begin
            // The reserved mode is refused and the old mode kept
            if (i_wdata[BIT_PAT_MODE_LO+1 -: 2] != MODE_RESERVED)
               mode_next = i_wdata[BIT_PAT_MODE_LO+1 -: 2]; // [RULE13]
            dir_next = i_wdata[BIT_PAT_DIR]; // [RULE14]
            start_bit_next = i_wdata[BIT_PAT_START];
         end
         start_pulse_next = start_bit_next && !start_bit_reg; // [RULE15]
         unframed_next = (mode_next == MODE_UNFRAMED); // [RULE11]
         msb7_next = (mode_next == MODE_7BIT); // [RULE12] [RULE13]
      end

      always_ff @(posedge i_clock or negedge rst_sync_reg)
      begin
         if (!rst_sync_reg)
         begin
            mode_reg <= MODE_UNFRAMED;
            dir_reg <= 1'b0;
            start_bit_reg <= 1'b0;
            start_pulse_reg <= 1'b0;
            unframed_reg <= 1'b1;
            msb7_reg <= 1'b0;
         end
         else
         begin
            mode_reg <= mode_next;
            dir_reg <= dir_next;
            start_bit_reg <= start_bit_next;
            start_pulse_reg <= start_pulse_next;
            unframed_reg <= unframed_next;
            msb7_reg <= msb7_next;
         end
      end

      // Indirect access engine
      always_comb
      begin
         wr_ctrl = i_wr && reg_hit(i_addr, l, OFF_ACC_CTRL);
         ctrl_next = ctrl_reg;
         data_next = data_reg;
         state_next = state_reg;
         cnt_next = cnt_reg;
         mem_we = 1'b0;
         unique case (state_reg)
            ACC_IDLE:
            begin
               if (i_wr && reg_hit(i_addr, l, OFF_ACC_DATA))
                  data_next = i_wdata; // [RULE21]
               if (wr_ctrl)
               begin
                  ctrl_next = i_wdata;
                  if (ind_addr_ok(i_wdata[6:0])) // [RULE19]
                  begin
                     state_next = ACC_BUSY; // [RULE16]
                     cnt_next = ACCESS_CNT_LAST;
                  end
               end
            end
            ACC_BUSY:
            begin
               // Writes to control or data while busy are dropped [RULE17]
               if (cnt_reg == 4'h0)
               begin
                  state_next = ACC_IDLE;
                  if (ctrl_reg[BIT_ACC_DIR])
                     data_next = ind_mem[ctrl_reg[6:0]]; // [RULE18] [RULE22]
                  else
                     mem_we = 1'b1; // [RULE18]
               end
               else
                  cnt_next = cnt_reg - 4'h1;
            end
         endcase
         busy_next = (state_next == ACC_BUSY); // [RULE16]
      end

      always_ff @(posedge i_clock or negedge rst_sync_reg)
      begin
         if (!rst_sync_reg)
         begin
            crc_error_overflow_irq_enable_reg <= 1'b0;
            line_violation_overflow_irq_enable_reg <= 1'b0;
            flags0_reg <= RST_BYTE;
            line_violation_overflow_flag_reg <= 1'b0;
         end
         else
         begin
            crc_error_overflow_irq_enable_reg <= crc_error_overflow_irq_enable_next;
            line_violation_overflow_irq_enable_reg <= line_violation_overflow_irq_enable_next;
            flags0_reg <= flags0_next;
            line_violation_overflow_flag_reg <= line_violation_overflow_flag_next;
         end
      end

      // Busy has its own flop so the pin comes from a register
      always_ff @(posedge i_clock or negedge rst_sync_reg)
      begin
         if (!rst_sync_reg)
         begin
            ctrl_reg <= RST_BYTE;
            data_reg <= RST_BYTE;
            state_reg <= ACC_IDLE;
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
         end
         else
         begin
            ctrl_reg <= ctrl_next;
            data_reg <= data_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
         end
      end

      // Indirect register storage, not reset
      always_ff @(posedge i_clock)
      begin
         if (mem_we)
            ind_mem[ctrl_reg[6:0]] <= data_reg; // [RULE18]
      end

      // Read view of this link's page
      always_comb
      begin
         link_rdata[l] = RST_BYTE;
         unique case (i_addr[7:0])
            OFF_IRQ_EN0: link_rdata[l][BIT_CRC_EN] = crc_error_overflow_irq_enable_reg;
            OFF_IRQ_EN1: link_rdata[l][BIT_LCV_EN] = line_violation_overflow_irq_enable_reg;
            OFF_FLAGS0: link_rdata[l] = flags0_reg;
            OFF_FLAGS1: link_rdata[l][BIT_LCV_FLAG] = line_violation_overflow_flag_reg;
            OFF_PAT_CFG: link_rdata[l] = {4'h0, mode_reg, dir_reg, start_bit_reg};
            OFF_ACC_STAT: link_rdata[l][BIT_BUSY] = (state_reg == ACC_BUSY); // [RULE16]
            OFF_ACC_CTRL: link_rdata[l] = ctrl_reg;
            OFF_ACC_DATA: link_rdata[l] = data_reg;
            default: link_rdata[l] = RST_BYTE;
         endcase
      end

      always_comb
      begin
         link_irq[l] = (crc_error_overflow_irq_enable_reg && flags0_next[BIT_CRC_FLAG]) || // [RULE1]
            (line_violation_overflow_irq_enable_reg && line_violation_overflow_flag_next); // [RULE2]
      end

      assign o_pattern_extract_mode[2*l +: 2] = mode_reg;
      assign o_pattern_unframed[l] = unframed_reg;
      assign o_pattern_msb7_only[l] = msb7_reg;
      assign o_pattern_gen_in_rx[l] = dir_reg; // [RULE14]
      assign o_pattern_start[l] = start_pulse_reg;
      assign o_access_busy[l] = busy_reg; // [RULE16]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data and interrupt

   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic irq_next;

   // Read data stands for the one cycle after the strobe
   always_comb
   begin
      rdata_next = RST_BYTE;
      if (i_rd && (int'(i_addr[10:8]) < NUM_LINKS))
         rdata_next = link_rdata[i_addr[10:8]]; // [RULE20]
   end

   // Interrupt line
   always_comb
   begin
      irq_next = |link_irq; // [RULE23]
   end

   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_next;
   end

   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         rdata_reg <= RST_BYTE;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_irq = irq_reg;
endmodule

// ==== src/tpr_pkg.sv ====
// Register map, field positions, reset values and timing for the per-link control slice
package tpr_pkg;
   // Register offsets inside one link's page
   localparam logic [7:0] OFF_IRQ_EN0 = 8'hc3;
   localparam logic [7:0] OFF_IRQ_EN1 = 8'hc4;
   localparam logic [7:0] OFF_FLAGS0 = 8'hc5;
   localparam logic [7:0] OFF_FLAGS1 = 8'hc6;
   localparam logic [7:0] OFF_PAT_CFG = 8'hc7;
   localparam logic [7:0] OFF_ACC_STAT = 8'hc8;
   localparam logic [7:0] OFF_ACC_CTRL = 8'hc9;
   localparam logic [7:0] OFF_ACC_DATA = 8'hca;
   // Field positions
   localparam int BIT_CRC_EN = 0;
   localparam int BIT_LCV_EN = 0;
   localparam int BIT_PAT_FLAG = 7;
   localparam int BIT_DDS_FLAG = 4;
   localparam int BIT_COFA_FLAG = 3;
   localparam int BIT_OOF_FLAG = 2;
   localparam int BIT_FER_FLAG = 1;
   localparam int BIT_CRC_FLAG = 0;
   localparam int BIT_LCV_FLAG = 0;
   localparam int BIT_PAT_START = 0;
   localparam int BIT_PAT_DIR = 1;
   localparam int BIT_PAT_MODE_LO = 2;
   localparam int BIT_BUSY = 0;
   localparam int BIT_ACC_DIR = 7;
   // Pattern extract modes
   localparam logic [1:0] MODE_UNFRAMED = 2'h0;
   localparam logic [1:0] MODE_8BIT = 2'h1;
   localparam logic [1:0] MODE_7BIT = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;
   // Valid indirect address windows
   localparam logic [6:0] IND_LO0 = 7'h01;
   localparam logic [6:0] IND_HI0 = 7'h18;
   localparam logic [6:0] IND_LO1 = 7'h21;
   localparam logic [6:0] IND_HI1 = 7'h38;
   localparam logic [6:0] IND_LO2 = 7'h41;
   localparam logic [6:0] IND_HI2 = 7'h58;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Indirect access time and its cycle count at 100 MHz
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACCESS_TIME_NS = 40;
   localparam int ACCESS_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] ACCESS_CNT_LAST = 4'(ACCESS_CYCLES - 1);
   typedef enum logic {ACC_IDLE, ACC_BUSY} tpr_acc_e;
endpackage

// ==== tb/tpr_regs_props.sv ====
// Port-level assertions for the per-link control slice
module tpr_regs_props
   import tpr_pkg::*;
#(
   parameter int NUM_LINKS = 8
)
(
   // Clock, reset and register port
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [10:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   // Events
   input wire logic [NUM_LINKS-1:0] i_crc_error_ovf,
   input wire logic [NUM_LINKS-1:0] i_line_violation_ovf,
   // Outputs under watch
   input wire logic o_irq,
   input wire logic [2*NUM_LINKS-1:0] o_pattern_extract_mode,
   input wire logic [NUM_LINKS-1:0] o_pattern_unframed,
   input wire logic [NUM_LINKS-1:0] o_pattern_msb7_only,
   input wire logic [NUM_LINKS-1:0] o_pattern_gen_in_rx,
   input wire logic [NUM_LINKS-1:0] o_pattern_start,
   input wire logic [NUM_LINKS-1:0] o_access_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   localparam logic [10:0] CTRL0 = {3'h0, OFF_ACC_CTRL};
   localparam logic [10:0] CFG0 = {3'h0, OFF_PAT_CFG};
   function automatic logic ok7(input logic [6:0] a);
      return (a >= IND_LO0 && a <= IND_HI0) || (a >= IND_LO1 && a <= IND_HI1)
         || (a >= IND_LO2 && a <= IND_HI2);
   endfunction
   sequence acc_req;
      i_wr && !o_access_busy[0] && i_addr == CTRL0;
   endsequence
   sequence busy_run;
      o_access_busy[0] [*4] ##1 !o_access_busy[0];
   endsequence
   chk_busy_span: assert property (acc_req ##0 ok7(i_wdata[6:0]) |=> busy_run)
      else $error("busy span wrong");
   chk_bad_addr: assert property (acc_req ##0 !ok7(i_wdata[6:0]) |=> !o_access_busy[0])
      else $error("busy on bad address");
   chk_unframed_mode: assert property (o_pattern_unframed[0]
      == (o_pattern_extract_mode[1:0] == MODE_UNFRAMED))
      else $error("unframed flag wrong");
   chk_msb7_mode: assert property (o_pattern_msb7_only[0]
      == (o_pattern_extract_mode[1:0] == MODE_7BIT))
      else $error("msb7 flag wrong");
   chk_mode_legal: assert property (o_pattern_extract_mode[1:0] != MODE_RESERVED)
      else $error("reserved mode taken");
   chk_mode_cause: assert property ($changed(o_pattern_extract_mode[1:0])
      |-> $past(i_wr) && $past(i_addr) == CFG0)
      else $error("mode changed without write");
   chk_dir_cause: assert property ($changed(o_pattern_gen_in_rx[0])
      |-> $past(i_wr) && $past(i_addr) == CFG0)
      else $error("direction changed without write");
   chk_start_cause: assert property (o_pattern_start[0]
      |-> $past(i_wr) && $past(i_addr) == CFG0 && $past(i_wdata[0]) ##1 !o_pattern_start[0])
      else $error("start pulse without write");
   chk_irq_rise: assert property ($rose(o_irq)
      |-> $past(|i_crc_error_ovf || |i_line_violation_ovf || i_wr) || $past(i_wr, 2))
      else $error("interrupt rose without cause");
   chk_irq_fall: assert property ($fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2))
      else $error("interrupt fell without write");
endmodule
bind tpr_regs tpr_regs_props #(.NUM_LINKS(NUM_LINKS)) u_props (.i_clock(i_clock),
   .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_crc_error_ovf(i_crc_error_ovf), .i_line_violation_ovf(i_line_violation_ovf),
   .o_irq(o_irq), .o_pattern_extract_mode(o_pattern_extract_mode),
   .o_pattern_unframed(o_pattern_unframed), .o_pattern_msb7_only(o_pattern_msb7_only),
   .o_pattern_gen_in_rx(o_pattern_gen_in_rx), .o_pattern_start(o_pattern_start),
   .o_access_busy(o_access_busy));

// ==== tb/testbench.sv ====
// Self-checking bench for the per-link control slice
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tpr_pkg::*;
   logic i_clock = 0;
   logic i_rst_n = 0;
   logic [10:0] i_addr = '0;
   logic [7:0] i_wdata = '0;
   logic i_wr = 0;
   logic i_rd = 0;
   logic rd_d = 0;
   logic [7:0] ev [7] = '{default: '0};
   logic [7:0] o_rdata;
   logic o_irq;
   logic [15:0] o_pattern_extract_mode;
   logic [7:0] o_pattern_unframed, o_pattern_msb7_only, o_pattern_gen_in_rx;
   logic [7:0] o_pattern_start, o_access_busy;
   logic [7:0] q [$];
   logic [7:0] off, d, en;
   int err_count = 0;
   int samples_checked = 0;
   int l;
   int bpos [7] = '{7, 4, 3, 2, 1, 0, 0};
   ////////////////////////////////////////////////////////////////////////////
   tpr_regs #(.NUM_LINKS(8)) dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_pattern_err_ovf(ev[0]), .i_digital_service_ovf(ev[1]), .i_align_change_ovf(ev[2]),
      .i_frame_loss_ovf(ev[3]), .i_framing_bit_ovf(ev[4]), .i_crc_error_ovf(ev[5]),
      .i_line_violation_ovf(ev[6]), .o_irq(o_irq),
      .o_pattern_extract_mode(o_pattern_extract_mode), .o_pattern_unframed(o_pattern_unframed),
      .o_pattern_msb7_only(o_pattern_msb7_only), .o_pattern_gen_in_rx(o_pattern_gen_in_rx),
      .o_pattern_start(o_pattern_start), .o_access_busy(o_access_busy));
   initial
      forever #5 i_clock = ~i_clock;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [10:0] ad(input int k, input logic [7:0] o);
      return {3'(k), o};
   endfunction
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] dt);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= dt;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      q.push_back(e);
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask
   task automatic pulse(input int k, input int ln);
      @(posedge i_clock);
      ev[k][ln] <= 1'b1;
      @(posedge i_clock);
      ev[k][ln] <= 1'b0;
      #1;
   endtask
   task automatic wt(input int ln);
      for (int n = 0; n < 20 && o_access_busy[ln] !== 1'b0; n++)
         @(posedge i_clock);
      #1;
      chk("busy done", o_access_busy[ln], 1'b0);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Read data checker: one queued note per read
   always @(posedge i_clock)
      rd_d <= i_rd;
   always @(negedge i_clock)
      if (rd_d) chk("rdata", o_rdata, q.pop_front());
   initial
   begin
      repeat (5000) @(posedge i_clock);
      err_count++;
      summarize();
   end
   initial
   begin
      void'($urandom(32'hee0f));
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      // Reset values, the last offset is unmapped
      for (int o = 8'hc3; o <= 8'hcb; o++)
         rd(ad(0, 8'(o)), 8'h00);
      // Each overflow flag: set, masked, per link, write-0 keeps, write-1 clears
      for (int k = 0; k < 7; k++)
      begin
         l = $urandom % 8;
         off = (k == 6) ? OFF_FLAGS1 : OFF_FLAGS0;
         pulse(k, l);
         chk("irq masked", o_irq, 1'b0);
         rd(ad(l, off), 8'(1 << bpos[k]));
         rd(ad((l + 1) % 8, off), 8'h00);
         wr(ad(l, off), ~8'(1 << bpos[k]));
         rd(ad(l, off), 8'(1 << bpos[k]));
         wr(ad(l, off), 8'(1 << bpos[k]));
         rd(ad(l, off), 8'h00);
      end
      // Interrupt gating by the two enables
      for (int k = 5; k < 7; k++)
      begin
         l = $urandom % 8;
         off = (k == 6) ? OFF_FLAGS1 : OFF_FLAGS0;
         en = (k == 6) ? OFF_IRQ_EN1 : OFF_IRQ_EN0;
         wr(ad(l, en), 8'h01);
         pulse(k, l);
         chk("irq", o_irq, 1'b1);
         wr(ad(l, off), 8'h01);
         #1;
         chk("irq cleared", o_irq, 1'b0);
         wr(ad(l, en), 8'h00);
         pulse(k, l);
         chk("irq off", o_irq, 1'b0);
         wr(ad(l, off), 8'h01);
      end
      // Every extract mode and direction, reserved mode refused
      for (int m = 0; m < 4; m++)
      begin
         d = {4'h0, 2'(m), 1'(m), 1'b0};
         wr(ad(0, OFF_PAT_CFG), d);
         if (m == 3)
            d[3:2] = MODE_7BIT;
         rd(ad(0, OFF_PAT_CFG), d);
         chk("mode", o_pattern_extract_mode[1:0], d[3:2]);
         chk("unframed", o_pattern_unframed[0], d[3:2] == MODE_UNFRAMED);
         chk("msb7", o_pattern_msb7_only[0], d[3:2] == MODE_7BIT);
         chk("gen rx", o_pattern_gen_in_rx[0], d[1]);
      end
      wr(ad(0, OFF_PAT_CFG), 8'h01);
      #1;
      chk("start", o_pattern_start[0], 1'b1);
      @(posedge i_clock);
      #1;
      chk("start once", o_pattern_start[0], 1'b0);
      wr(ad(0, OFF_PAT_CFG), 8'h01);
      #1;
      chk("no retrigger", o_pattern_start[0], 1'b0);
      // Indirect write, data write while busy ignored, then read back
      d = 8'($urandom);
      wr(ad(0, OFF_ACC_DATA), d);
      wr(ad(0, OFF_ACC_CTRL), 8'h21);
      #1;
      chk("busy", o_access_busy[0], 1'b1);
      wr(ad(0, OFF_ACC_DATA), ~d);
      wt(0);
      rd(ad(0, OFF_ACC_STAT), 8'h00);
      wr(ad(0, OFF_ACC_DATA), 8'h00);
      wr(ad(0, OFF_ACC_CTRL), 8'ha1);
      rd(ad(0, OFF_ACC_STAT), 8'h01);
      wt(0);
      rd(ad(0, OFF_ACC_DATA), d);
      rd(ad(0, OFF_ACC_CTRL), 8'ha1);
      wr(ad(0, OFF_ACC_CTRL), 8'h19);
      #1;
      chk("busy bad address", o_access_busy[0], 1'b0);
      repeat (2) @(posedge i_clock);
      summarize();
   end
endmodule
